// >>> design/lcf_pkg.sv
/*
 * Shared constants for one LIN frame channel: register indices, field
 * positions, reset values, frame timing limits and the sequencer states.
 * Assumes a 20 MHz system clock and a byte-wide register port.
 */
`default_nettype none

package lcf_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int AW = 3;
    localparam int DW = 8;

    // Register indices on the plain port
    localparam logic [2:0] OFS_MODE = 3'h0;
    localparam logic [2:0] OFS_BREAK = 3'h1;
    localparam logic [2:0] OFS_RFC = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_CTRL = 3'h4;
    localparam logic [2:0] OFS_SUMMARY = 3'h5;
    localparam logic [2:0] OFS_BUF_IDX = 3'h6;
    localparam logic [2:0] OFS_BUF_DATA = 3'h7;

    // Status and interrupt enable layout (same bit per source)
    localparam int ST_DONE = 0;
    localparam int ST_ERR = 1;
    localparam int ST_CSUM = 2;
    localparam int ST_LOW = 3;
    localparam int NFLAG = 4;
    localparam int MODE_LOW_EN = 4;
    localparam int RFC_DIR = 4;
    localparam int CTRL_START = 0;
    localparam int CTRL_BREAK = 1;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [5:0] BREAK_RST = 6'h00;
    localparam logic [4:0] RFC_RST = 5'h01;

    // Frame timing in bit times
    localparam logic [4:0] BRK_MIN_BITS = 5'h0D;
    localparam logic [4:0] DLM_MIN_BITS = 5'h01;
    localparam logic [4:0] IBS_BITS = 5'h01;
    localparam logic [4:0] LAST_FRAME_BIT = 5'h09;
    localparam logic [3:0] MAX_BYTES = 4'h8;
    localparam int BAUD_BPS = 19_200;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_BREAK = 3'b001,
        S_DELIM = 3'b010,
        S_TXB = 3'b011,
        S_IBS = 3'b100,
        S_RXB = 3'b101
    } lcf_state_e;
endpackage : lcf_pkg

`default_nettype wire

// >>> design/lcf_buf.sv
/*
 * Small response data buffer: one write port, two read ports whose data
 * come out of registers one cycle after the address.
 * Assumes the caller arbitrates the single write port.
 */
`default_nettype none

module lcf_buf #(
    parameter int W = 8,
    parameter int D = 8,
    parameter int AW = 3
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [W-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [W-1:0] rdata_b
);
    logic [W-1:0] mem [D];

    if (D > (1 << AW))
    begin : g_chk
        $error("lcf_buf depth exceeds address range");
    end

    // Array itself needs no reset; read registers do
    always_ff @(posedge clk_sys)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_a <= '0;
            rdata_b <= '0;
        end
        else
        begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule : lcf_buf

`default_nettype wire

// >>> design/lcf_channel.sv
/*
 * One LIN channel: break and delimiter transmit, byte-wise response
 * transmit and receive with interbyte space and checksum, input low
 * detection, sticky status flags and one aggregated interrupt.
 * Assumes the bus input is synchronous to clk_sys and that the three
 * other channels' low-detect flags arrive on other_low_detect.
 */
// Behaviour
// - Flags cleared only by software writing zero
// - Low-detect summary set blocks new requests
// - Break low length 13 to 28 bits
// - Delimiter high length 1 to 4 bits
// - Transmit bytes plus interbyte space; abort on error
// - Receive on start bit; error skips checksum
// - Low detect on edge or enable while low
// - Flag set with enable raises request
// - Shared line: no new request while pending
// - Summary bits read each channel's low-detect flag
`default_nettype none

module lcf_channel
    import lcf_pkg::*;
#(
    parameter int BIT_CLKS = CLK_HZ / BAUD_BPS,
    parameter int NBUF = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [lcf_pkg::AW-1:0] reg_addr,
    input wire logic [lcf_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lcf_pkg::DW-1:0] reg_rdata,
    input wire logic bus_input_pin,
    output logic bus_output_pin,
    input wire logic [2:0] other_low_detect,
    output logic low_detect_flag,
    output logic irq
);
    import lcf_pkg::*;

    localparam int CW = $clog2(BIT_CLKS + 1);
    localparam logic [CW-1:0] TICK_AT = CW'(BIT_CLKS - 1);
    localparam logic [CW-1:0] MID_AT = CW'(BIT_CLKS / 2);

    if (BIT_CLKS < 4 || NBUF != int'(MAX_BYTES))
    begin : g_chk
        $error("lcf_channel: unsupported BIT_CLKS or NBUF");
    end

    function automatic logic [3:0] nbytes(input logic [3:0] f);
        if (f == 4'h0)
            return 4'h1;
        else if (f > MAX_BYTES)
            return MAX_BYTES;
        else
            return f;
    endfunction : nbytes

    // Sum with end-around carry
    function automatic logic [7:0] csum_add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction : csum_add

    logic [4:0] mode_q;
    logic [5:0] brk_q;
    logic [4:0] rfc_q;
    logic [NFLAG-1:0] st_q;
    logic low_req_q;
    logic [2:0] idx_q;
    logic [7:0] rdat_q;
    logic sel_mem_q;
    lcf_state_e state_q;
    logic [CW-1:0] cyc_q;
    logic [4:0] bit_q;
    logic [3:0] byte_q;
    logic [9:0] sh_q;
    logic [7:0] sum_q;
    logic in_byte_q;
    logic [2:0] ev_q;
    logic rx_prev_q;
    logic low_en_prev_q;
    logic irq_q;
    logic tx_q;
    logic [7:0] mem_a;
    logic [7:0] mem_b;

    logic bit_tick;
    logic mid;
    logic [3:0] n;
    logic [4:0] brk_bits;
    logic [4:0] dlm_bits;
    logic [7:0] tx_byte;
    logic start;
    logic rx_store;
    logic buf_wr;
    logic low_set;
    logic [NFLAG-1:0] st_set;

    assign bit_tick = (cyc_q == TICK_AT);
    assign mid = (cyc_q == MID_AT);
    assign n = nbytes(rfc_q[3:0]);
    assign brk_bits = BRK_MIN_BITS + {1'b0, brk_q[3:0]};
    assign dlm_bits = DLM_MIN_BITS + {3'h0, brk_q[5:4]};
    assign tx_byte = (byte_q == n) ? ~sum_q : mem_b;
    assign start = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START] && state_q == S_IDLE;
    assign rx_store = state_q == S_RXB && in_byte_q && mid && bit_q == LAST_FRAME_BIT
        && bus_input_pin && byte_q < n;
    assign buf_wr = reg_wr && reg_addr == OFS_BUF_DATA && state_q == S_IDLE;
    // Edge while enabled, or enable rising while already low
    assign low_set = mode_q[MODE_LOW_EN] && !bus_input_pin && (rx_prev_q || !low_en_prev_q);
    assign st_set = {low_set, ev_q};

    lcf_buf #(.W(8), .D(NBUF), .AW(3)) u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .we(rx_store || buf_wr),
        .waddr(rx_store ? byte_q[2:0] : idx_q),
        .wdata(rx_store ? sh_q[7:0] : reg_wdata),
        .raddr_a(idx_q),
        .rdata_a(mem_a),
        .raddr_b(byte_q[2:0]),
        .rdata_b(mem_b)
    );

    // Configuration registers and buffer index
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= MODE_RST;
            brk_q <= BREAK_RST;
            rfc_q <= RFC_RST;
            idx_q <= '0;
        end
        else if (reg_wr && reg_addr == OFS_MODE)
            mode_q <= reg_wdata[4:0];
        else if (reg_wr && reg_addr == OFS_BREAK)
            brk_q <= reg_wdata[5:0];
        else if (reg_wr && reg_addr == OFS_RFC)
            rfc_q <= reg_wdata[4:0];
        else if (reg_wr && reg_addr == OFS_BUF_IDX)
            idx_q <= reg_wdata[2:0];
        else if ((reg_wr || reg_rd) && reg_addr == OFS_BUF_DATA)
            idx_q <= idx_q + 3'h1;
    end

    // Sticky flags: write 0 clears, write 1 keeps, hardware set wins
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st_q <= '0;
        else if (reg_wr && reg_addr == OFS_STATUS)
            st_q <= (st_q & reg_wdata[NFLAG-1:0]) | st_set;
        else
            st_q <= st_q | st_set;
    end

    // Low-detect request only opens while no channel shows low detect
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            low_req_q <= 1'b0;
        else if (low_set && other_low_detect == 3'h0 && !st_q[ST_LOW])
            low_req_q <= 1'b1;
        else if (!st_q[ST_LOW])
            low_req_q <= 1'b0;
    end

    // One shared level: a second source cannot make a fresh edge
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            irq_q <= 1'b0;
        else
            irq_q <= (|(st_q[2:0] & mode_q[2:0])) || (low_req_q && st_q[ST_LOW] && mode_q[ST_LOW]);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_prev_q <= 1'b1;
            low_en_prev_q <= 1'b0;
        end
        else
        begin
            rx_prev_q <= bus_input_pin;
            low_en_prev_q <= mode_q[MODE_LOW_EN];
        end
    end

    // Read port: data stand in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdat_q <= '0;
            sel_mem_q <= 1'b0;
        end
        else
        begin
            sel_mem_q <= reg_rd && reg_addr == OFS_BUF_DATA;
            if (!reg_rd)
                rdat_q <= '0;
            else if (reg_addr == OFS_MODE)
                rdat_q <= {3'h0, mode_q};
            else if (reg_addr == OFS_BREAK)
                rdat_q <= {2'h0, brk_q};
            else if (reg_addr == OFS_RFC)
                rdat_q <= {3'h0, rfc_q};
            else if (reg_addr == OFS_STATUS)
                rdat_q <= {4'h0, st_q};
            else if (reg_addr == OFS_CTRL)
                rdat_q <= {7'h00, state_q != S_IDLE};
            else if (reg_addr == OFS_SUMMARY)
                rdat_q <= {4'h0, other_low_detect, st_q[ST_LOW]};
            else if (reg_addr == OFS_BUF_IDX)
                rdat_q <= {5'h00, idx_q};
            else
                rdat_q <= '0;
        end
    end

    // Frame sequencer
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= S_IDLE;
            cyc_q <= '0;
            bit_q <= '0;
            byte_q <= '0;
            sh_q <= '1;
            sum_q <= '0;
            tx_q <= 1'b1;
            in_byte_q <= 1'b0;
            ev_q <= '0;
        end
        else
        begin
            ev_q <= '0;
            cyc_q <= bit_tick ? '0 : cyc_q + 1'b1;
            case (state_q)
                S_IDLE:
                begin
                    tx_q <= 1'b1;
                    cyc_q <= '0;
                    bit_q <= '0;
                    byte_q <= '0;
                    sum_q <= '0;
                    in_byte_q <= 1'b0;
                    if (start && !rfc_q[RFC_DIR])
                        state_q <= S_RXB;
                    else if (start && reg_wdata[CTRL_BREAK])
                    begin
                        // Line drops at the start edge so the low lasts the full count
                        tx_q <= 1'b0;
                        state_q <= S_BREAK;
                    end
                    else if (start)
                        state_q <= S_IBS;
                end
                S_BREAK:
                begin
                    tx_q <= 1'b0;
                    if (bit_tick && bit_q == brk_bits - 5'h01)
                    begin
                        bit_q <= '0;
                        tx_q <= 1'b1;
                        state_q <= S_DELIM;
                    end
                    else if (bit_tick)
                        bit_q <= bit_q + 5'h01;
                end
                S_DELIM, S_IBS:
                begin
                    if (state_q == S_IBS && bit_tick && bit_q == IBS_BITS - 5'h01 && byte_q > n)
                    begin
                        ev_q[ST_DONE] <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else if (bit_tick && bit_q == (state_q == S_DELIM ? dlm_bits : IBS_BITS) - 5'h01)
                    begin
                        bit_q <= '0;
                        tx_q <= 1'b0;
                        sh_q <= {1'b1, tx_byte, 1'b0};
                        if (byte_q < n)
                            sum_q <= csum_add(sum_q, tx_byte);
                        state_q <= S_TXB;
                    end
                    else if (bit_tick)
                        bit_q <= bit_q + 5'h01;
                end
                S_TXB:
                begin
                    if (mid && bus_input_pin != tx_q)
                    begin
                        ev_q[ST_ERR] <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else if (bit_tick && bit_q == LAST_FRAME_BIT)
                    begin
                        bit_q <= '0;
                        tx_q <= 1'b1;
                        byte_q <= byte_q + 4'h1;
                        state_q <= S_IBS;
                    end
                    else if (bit_tick)
                    begin
                        sh_q <= {1'b1, sh_q[9:1]};
                        tx_q <= sh_q[1];
                        bit_q <= bit_q + 5'h01;
                    end
                end
                S_RXB:
                begin
                    tx_q <= 1'b1;
                    if (!in_byte_q)
                    begin
                        cyc_q <= '0;
                        bit_q <= '0;
                        if (rx_prev_q && !bus_input_pin)
                            in_byte_q <= 1'b1;
                    end
                    else if (mid && (bit_q == 5'h00 ? bus_input_pin : (bit_q == LAST_FRAME_BIT && !bus_input_pin)))
                    begin
                        ev_q[ST_ERR] <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else if (mid && bit_q == LAST_FRAME_BIT)
                    begin
                        in_byte_q <= 1'b0;
                        byte_q <= byte_q + 4'h1;
                        if (byte_q < n)
                            sum_q <= csum_add(sum_q, sh_q[7:0]);
                        else
                        begin
                            ev_q[ST_CSUM] <= sh_q[7:0] != ~sum_q;
                            ev_q[ST_DONE] <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                    else if (mid && bit_q != 5'h00)
                        sh_q <= {sh_q[9:8], bus_input_pin, sh_q[7:1]};
                    else if (bit_tick)
                        bit_q <= bit_q + 5'h01;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    assign bus_output_pin = tx_q;
    assign low_detect_flag = st_q[ST_LOW];
    assign irq = irq_q;
    // Buffer data come from the buffer's own output register
    assign reg_rdata = sel_mem_q ? mem_a : rdat_q;

    // Cycles spent in the current sequencer state
    int unsigned len_q;
    lcf_state_e prev_q;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            len_q <= 0;
            prev_q <= S_IDLE;
        end
        else
        begin
            prev_q <= state_q;
            len_q <= (prev_q != state_q) ? 1 : len_q + 1;
        end
    end

    sequence s_leave_break;
        state_q == S_BREAK ##1 state_q == S_DELIM;
    endsequence

    sequence s_leave_delim;
        state_q == S_DELIM ##1 state_q == S_TXB;
    endsequence

    property p_flag_sticky;
        @(posedge clk_sys) disable iff (!resetn)
        1 |=> (($past(st_q) & ~st_q & ($past(reg_wr && reg_addr == OFS_STATUS) ? $past(reg_wdata[3:0]) : 4'hF)) == 4'h0);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("status flag dropped without a zero write");

    property p_low_block;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(low_req_q) |-> $past(other_low_detect == 3'h0 && !st_q[ST_LOW]);
    endproperty
    a_low_block: assert property (p_low_block) else $error("low-detect request while summary set");

    // len_q at the first cycle of the next state holds the full stay
    property p_break_len;
        @(posedge clk_sys) disable iff (!resetn)
        s_leave_break |-> (len_q == BIT_CLKS * (int'(BRK_MIN_BITS) + $past(brk_q[3:0]))) && bus_output_pin;
    endproperty
    a_break_len: assert property (p_break_len) else $error("break length mismatch");

    property p_delim_len;
        @(posedge clk_sys) disable iff (!resetn)
        s_leave_delim |-> len_q == BIT_CLKS * (int'(DLM_MIN_BITS) + $past(brk_q[5:4])) && !bus_output_pin;
    endproperty
    a_delim_len: assert property (p_delim_len) else $error("delimiter length mismatch");

    sequence s_leave_byte;
        state_q == S_TXB ##1 state_q != S_TXB;
    endsequence

    property p_tx_ibs;
        @(posedge clk_sys) disable iff (!resetn)
        s_leave_byte |-> (state_q == S_IBS && bus_output_pin)
            || (state_q == S_IDLE && ev_q[ST_ERR]);
    endproperty
    a_tx_ibs: assert property (p_tx_ibs) else $error("byte not followed by interbyte space");

    property p_err_abort;
        @(posedge clk_sys) disable iff (!resetn)
        ev_q[ST_ERR] |-> state_q == S_IDLE && !ev_q[ST_CSUM] && !ev_q[ST_DONE] ##1 st_q[ST_ERR];
    endproperty
    a_err_abort: assert property (p_err_abort) else $error("error did not abort the frame");

    property p_low_edge;
        @(posedge clk_sys) disable iff (!resetn)
        (mode_q[MODE_LOW_EN] && rx_prev_q && !bus_input_pin) |=> st_q[ST_LOW];
    endproperty
    a_low_edge: assert property (p_low_edge) else $error("low detect missed");

    property p_irq;
        @(posedge clk_sys) disable iff (!resetn)
        (|(st_q[2:0] & mode_q[2:0])) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing for enabled flag");

    property p_irq_fall;
        @(posedge clk_sys) disable iff (!resetn)
        st_q == '0 |=> !irq;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt without a set flag");

    property p_summary;
        @(posedge clk_sys) disable iff (!resetn)
        (reg_rd && reg_addr == OFS_SUMMARY) |=> reg_rdata == {4'h0, $past(other_low_detect), $past(st_q[ST_LOW])};
    endproperty
    a_summary: assert property (p_summary) else $error("summary read mismatch");
endmodule : lcf_channel

`default_nettype wire

// >>> verif/lcf_node.sv
/*
 * Far LIN node: drives its share of the wired-AND bus.
 * Assumes the bench ANDs node_tx with the channel's output; idle is the pull-up level.
 */
`default_nettype none

module lcf_node #(
    parameter int BIT = 8
) (
    input wire logic clk_sys,
    output logic node_tx
);
    timeunit 1ns;
    timeprecision 1ns;

    initial node_tx = 1'b1;

    // One byte, then one bit time released; stp low breaks framing
    task automatic send_byte(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            node_tx <= f[i];
            repeat (BIT) @(posedge clk_sys);
        end
        node_tx <= 1'b1;
        repeat (BIT) @(posedge clk_sys);
    endtask : send_byte

    task automatic hold_low(input int n);
        node_tx <= 1'b0;
        repeat (n) @(posedge clk_sys);
        node_tx <= 1'b1;
    endtask : hold_low
endmodule : lcf_node

`default_nettype wire

// >>> verif/tb_lcf_channel.sv
/*
 * Self-checking bench for one LIN frame channel with a far node model.
 * Assumes BIT_CLKS of 8 and the register map of lcf_pkg.
 */
`default_nettype none

module tb_lcf_channel;
    timeunit 1ns;
    timeprecision 1ns;
    import lcf_pkg::*;

    localparam int BIT = 8;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] other_low = 3'h0;
    logic [7:0] reg_rdata;
    logic bus_output_pin;
    logic low_detect_flag;
    logic irq;
    logic node_tx;
    logic lin;
    logic [7:0] rv;
    logic [7:0] dat [0:8];
    int miscompares = 0;
    int num_checks = 0;
    int seed = 32'h3697;

    assign lin = bus_output_pin & node_tx;
    always #25 clk_sys = ~clk_sys;

    lcf_channel #(.BIT_CLKS(BIT), .NBUF(8)) i_lcf_channel (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_input_pin(lin), .bus_output_pin(bus_output_pin),
        .other_low_detect(other_low), .low_detect_flag(low_detect_flag), .irq(irq));
    lcf_node #(.BIT(BIT)) i_lcf_node (.clk_sys(clk_sys), .node_tx(node_tx));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s exp %0h got %0h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    // Called 1 ns after an edge; gives up after a bounded count
    task automatic wait_lin(input logic v, output int n);
        n = 0;
        while (lin !== v)
        begin
            @(posedge clk_sys);
            #1 n++;
            if (n > 600)
            begin
                miscompares++;
                wrap_up();
            end
        end
    endtask : wait_lin

    // Mid-bit sampling from the first low sample of the start bit
    task automatic get_byte(output logic [9:0] f);
        for (int i = 0; i < 10; i++)
        begin
            repeat (i == 0 ? BIT / 2 : BIT) @(posedge clk_sys);
            #1 f[i] = lin;
        end
    endtask : get_byte

    function automatic logic [7:0] csum(input int n);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < n; i++)
        begin
            s = {1'b0, s[7:0]} + {1'b0, dat[i]};
            s = {1'b0, s[7:0]} + {8'h00, s[8]};
        end
        return ~s[7:0];
    endfunction : csum

    task automatic tx_test(input logic [3:0] bl, input logic [1:0] dl, input int n);
        logic [9:0] f;
        int c;
        wr(OFS_BREAK, {2'b00, dl, bl});
        wr(OFS_RFC, {4'h1, 4'(n)});
        wr(OFS_BUF_IDX, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            dat[i] = 8'($random(seed));
            wr(OFS_BUF_DATA, dat[i]);
        end
        dat[n] = csum(n);
        wr(OFS_CTRL, 8'h03);
        #1 wait_lin(1'b0, c);
        wait_lin(1'b1, c);
        chk("break_len", 16'((13 + bl) * BIT), 16'(c));
        wait_lin(1'b0, c);
        chk("delim_len", 16'((1 + dl) * BIT), 16'(c));
        for (int i = 0; i <= n; i++)
        begin
            get_byte(f);
            chk("tx_frame", {6'h00, 1'b1, dat[i], 1'b0}, {6'h00, f});
            if (i < n)
            begin
                wait_lin(1'b0, c);
                chk("ibs_len", 16'(BIT + BIT / 2), 16'(c));
            end
        end
        repeat (2 * BIT) @(posedge clk_sys);
        rd(OFS_STATUS);
        chk("tx_status", 16'h0001, {8'h00, rv});
        chk("irq_masked", 16'h0000, {15'h0, irq});
        wr(OFS_STATUS, 8'h00);
    endtask : tx_test

    // bad: 0 clean, 1 wrong checksum, 2 framing error on the first byte
    task automatic rx_test(input int n, input int bad);
        wr(OFS_RFC, {4'h0, 4'(n)});
        for (int i = 0; i < n; i++)
            dat[i] = 8'($random(seed));
        dat[n] = csum(n) ^ {7'h00, bad == 1};
        wr(OFS_CTRL, 8'h01);
        for (int i = 0; i <= (bad == 2 ? 0 : n); i++)
            i_lcf_node.send_byte(dat[i], !(bad == 2));
        repeat (2 * BIT) @(posedge clk_sys);
        rd(OFS_STATUS);
        chk("rx_status", bad == 2 ? 16'h2 : bad == 1 ? 16'h5 : 16'h1, {8'h00, rv});
        wr(OFS_BUF_IDX, 8'h00);
        for (int i = 0; i < n && bad == 0; i++)
        begin
            rd(OFS_BUF_DATA);
            chk("rx_data", {8'h00, dat[i]}, {8'h00, rv});
        end
        wr(OFS_STATUS, 8'h00);
    endtask : rx_test

    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 chk("rst_pins", 16'h4, {13'h0, bus_output_pin, irq, low_detect_flag});
        for (int a = 0; a < 4; a++)
        begin
            rd(3'(a));
            chk("rst_reg", {15'h0, a == 2}, {8'h00, rv});
        end
        tx_test(4'h0, 2'h0, 1);
        tx_test(4'hF, 2'h3, 8);
        tx_test(4'($random(seed)), 2'($random(seed)), 1 + ($unsigned($random(seed)) % 8));
        rx_test(1 + ($unsigned($random(seed)) % 8), 0);
        rx_test(8, 1);
        rx_test(1, 2);
        // Readback clash aborts a transmit and raises the error request
        wr(OFS_MODE, 8'h02);
        wr(OFS_RFC, 8'h11);
        wr(OFS_CTRL, 8'h01);
        i_lcf_node.hold_low(30 * BIT);
        rd(OFS_STATUS);
        chk("tx_err", 16'h0002, {8'h00, rv});
        chk("irq_err", 16'h0001, {15'h0, irq});
        rd(OFS_CTRL);
        chk("busy", 16'h0000, {15'h0, rv[0]});
        wr(OFS_STATUS, 8'hFF);
        rd(OFS_STATUS);
        chk("flag_kept", 16'h0002, {8'h00, rv});
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS);
        chk("flag_clr", 16'h0000, {8'h00, rv});
        chk("irq_clr", 16'h0000, {15'h0, irq});
        // Low detection on a falling edge, summary readback
        wr(OFS_MODE, 8'h18);
        i_lcf_node.hold_low(BIT);
        chk("low_edge", 16'h0003, {14'h0, low_detect_flag, irq});
        other_low <= 3'($random(seed));
        rd(OFS_SUMMARY);
        chk("summary", {8'h00, 4'h0, other_low, 1'b1}, {8'h00, rv});
        wr(OFS_MODE, 8'h00);
        wr(OFS_STATUS, 8'h00);
        // Another channel's flag blocks the new request
        other_low <= 3'h4;
        wr(OFS_MODE, 8'h18);
        i_lcf_node.hold_low(BIT);
        chk("low_blocked", 16'h0002, {14'h0, low_detect_flag, irq});
        other_low <= 3'h0;
        wr(OFS_MODE, 8'h00);
        wr(OFS_STATUS, 8'h00);
        // Flag drops on the clearing edge; look once it has settled
        @(posedge clk_sys);
        chk("low_cleared", 16'h0000, {14'h0, low_detect_flag, irq});
        // Enable while the line is already low
        fork
            i_lcf_node.hold_low(6 * BIT);
            wr(OFS_MODE, 8'h18);
        join
        chk("low_level", 16'h0003, {14'h0, low_detect_flag, irq});
        wrap_up();
    end
endmodule : tb_lcf_channel

`default_nettype wire
